// File: verilog/wdog_pkg.sv
package wdog_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int SHORT_BASE_MS = 1;
  localparam int PULSE_MS      = 5;
  localparam int EN_TO_BASE_MS = 100;
  localparam int EN_TO_STEP_MS = 100;
  localparam int EN_TO_MAX_MS  = 1400;
  localparam logic [3:0] EN_TO_MAX_SEL =
    4'((EN_TO_MAX_MS - EN_TO_BASE_MS) / EN_TO_STEP_MS);
  localparam int TW = 16;

  // register offsets
  localparam logic [7:0] ADDR_TIMING  = 8'h40;
  localparam logic [7:0] ADDR_MODE    = 8'h41;
  localparam logic [7:0] ADDR_RESTART = 8'h42;
  localparam logic [7:0] ADDR_LIMIT   = 8'h43;
  localparam logic [7:0] ADDR_SEED    = 8'h44;
  localparam logic [7:0] ADDR_CFG     = 8'h45;
  localparam logic [7:0] ADDR_QUEST   = 8'h46;
  localparam logic [7:0] ADDR_ANSWER  = 8'h47;
  localparam logic [7:0] ADDR_ATYPE   = 8'h48;
  localparam logic [7:0] ADDR_CLEAR   = 8'h49;
  localparam logic [7:0] ADDR_STATUS  = 8'h4A;

  // field positions
  localparam int SHORT_LSB   = 4;
  localparam int RATIO_LSB   = 0;
  localparam int OVR_BIT     = 4;
  localparam int PULSE_BIT   = 3;
  localparam int JUDGE_BIT   = 2;
  localparam int MODE_LSB    = 0;
  localparam int RESTART_BIT = 0;
  localparam int FC_LSB      = 4;
  localparam int LIMIT_LSB   = 0;
  localparam int FCCLR_BIT   = 1;
  localparam int FLGCLR_BIT  = 0;
  localparam int ST_WRONG    = 5;
  localparam int ST_LONG     = 4;
  localparam int ST_SHORT    = 3;
  localparam int ST_OPEN     = 2;
  localparam int ST_ERR      = 1;
  localparam int ST_BAD      = 0;

  // reset values
  localparam logic [2:0] SHORT_RST = 3'h0;
  localparam logic [1:0] RATIO_RST = 2'h2;
  localparam logic [1:0] LIMIT_RST = 2'h2;

  // fail counter
  localparam logic [3:0] FC_MAX   = 4'hF;
  localparam logic [3:0] BAD_INC  = 4'h1;
  localparam logic [3:0] LONG_INC = 4'h2;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_ACCESS = 2'b01,
    MODE_QA_LO  = 2'b10,
    MODE_QA_HI  = 2'b11
  } mode_t;

  function automatic logic [TW-1:0] short_ms(input logic [2:0] sel);
    return TW'(SHORT_BASE_MS) << sel;
  endfunction

  function automatic logic [TW-1:0] long_ms(input logic [TW-1:0] s,
                                            input logic [1:0]    r);
    return s << ({1'b0, r} + 3'h1);
  endfunction

  function automatic logic [3:0] fail_limit(input logic [1:0] code);
    logic [3:0] v;
    unique case (code)
      2'b00: v = 4'h1;
      2'b01: v = 4'h3;
      2'b10: v = 4'h7;
      2'b11: v = 4'hD;
    endcase
    return v;
  endfunction

  function automatic logic [4:0] next_question(input logic [4:0] q,
                                               input logic [4:0] seed,
                                               input logic [4:0] cfg);
    return {q[3:0], ~(q[4] ^ q[2])} ^ (seed ^ cfg);
  endfunction

  function automatic logic [7:0] expected_answer(input logic [4:0] q,
                                                 input logic [4:0] seed,
                                                 input logic [1:0] typ);
    logic [15:0] w;
    w = {q[2:0] ^ seed[2:0], q, q[2:0] ^ seed[2:0], q} << typ;
    return w[15:8];
  endfunction

endpackage

// File: verilog/wdog_link_port.sv
module wdog_link_port (
  input  wire logic       lnk_clk_i,
  input  wire logic       lnk_rst_i,
  input  wire logic       lnk_req_i,
  input  wire logic       lnk_wr_i,
  input  wire logic [7:0] lnk_addr_i,
  input  wire logic [7:0] lnk_wdata_i,
  input  wire logic       ack_tgl_i,
  input  wire logic [7:0] ref_rdata_i,
  output logic            lnk_busy_o,
  output logic            lnk_done_o,
  output logic [7:0]      lnk_rdata_o,
  output logic            req_tgl_o,
  output logic            hold_wr_o,
  output logic [7:0]      hold_addr_o,
  output logic [7:0]      hold_wdata_o
);

  logic       busy_r,  busy_nxt;
  logic       done_r,  done_nxt;
  logic       tgl_r,   tgl_nxt;
  logic       wr_r,    wr_nxt;
  logic [7:0] addr_r,  addr_nxt;
  logic [7:0] wdat_r,  wdat_nxt;
  logic [7:0] rdat_r,  rdat_nxt;
  logic       ack_s1_r, ack_s2_r, ack_s3_r;

  always_comb
  begin
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    tgl_nxt  = tgl_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    if (!busy_r && lnk_req_i)
    begin
      // capture, then hand over by toggle
      busy_nxt = 1'b1;
      tgl_nxt  = ~tgl_r;
      wr_nxt   = lnk_wr_i;
      addr_nxt = lnk_addr_i;
      wdat_nxt = lnk_wdata_i;
    end
    else if (busy_r && (ack_s2_r != ack_s3_r))
    begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
      rdat_nxt = ref_rdata_i;
    end
  end

  always_ff @(posedge lnk_clk_i)
  begin
    if (lnk_rst_i)
    begin
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      tgl_r    <= 1'b0;
      wr_r     <= 1'b0;
      addr_r   <= 8'h00;
      wdat_r   <= 8'h00;
      rdat_r   <= 8'h00;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end
    else
    begin
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
      tgl_r    <= tgl_nxt;
      wr_r     <= wr_nxt;
      addr_r   <= addr_nxt;
      wdat_r   <= wdat_nxt;
      rdat_r   <= rdat_nxt;
      ack_s1_r <= ack_tgl_i;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  assign lnk_busy_o   = busy_r;
  assign lnk_done_o   = done_r;
  assign lnk_rdata_o  = rdat_r;
  assign req_tgl_o    = tgl_r;
  assign hold_wr_o    = wr_r;
  assign hold_addr_o  = addr_r;
  assign hold_wdata_o = wdat_r;

endmodule // wdog_link_port

// File: verilog/question_answer_window_watchdog.sv
// Functional notes
// - short limit is 1 ms doubled per step of a 3-bit code
// - long limit is short limit times 2, 4, 8 or 16
// - keep-counting mode: each further long timeout adds two failures
// - restart mode: counter goes to zero after a long timeout
// - error drives interrupt low; optional 5 ms reset pulse
// - judge type 0 checks both limits, 1 checks long only
// - mode field: off, access monitoring, question and answer
// - mode written after reset release; cleared while reset low
// - restart bit clears the counter in access mode and reads back zero
// - error when fail count reaches 1, 3, 7 or 13
// - fail count readable as a 4-bit field
// - writable seed and config, read-only current question
// - fail-count clear bit zeroes counter and self-clears
// - flag clear bit clears long, short and bad flags
// - sticky flags for wrong answer, long, short and error
// - open flag set while counter lies between both limits
// - bad flag set by wrong answer, long or short timeout
// - enable timeout after reset release, 100 to 1400 ms
// - access mode times gaps between restart writes
module question_answer_window_watchdog #(
  parameter int MS_CYCLES = wdog_pkg::MS_CYCLES_DEF
) (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       lnk_clk_i,
  input  wire logic       lnk_rst_i,
  input  wire logic       lnk_req_i,
  input  wire logic       lnk_wr_i,
  input  wire logic [7:0] lnk_addr_i,
  input  wire logic [7:0] lnk_wdata_i,
  output logic            lnk_busy_o,
  output logic            lnk_done_o,
  output logic [7:0]      lnk_rdata_o,
  input  wire logic       watched_reset_n_i,
  input  wire logic       enable_timeout_switch_i,
  input  wire logic [3:0] enable_timeout_sel_i,
  output logic            interrupt_out_n_o,
  output logic            power_reset_out_n_o,
  output logic            enable_timeout_error_o
);
  import wdog_pkg::*;

  localparam int CW        = $clog2(MS_CYCLES);
  localparam int PULSE_CYC = PULSE_MS * MS_CYCLES;
  localparam int PW        = $clog2(PULSE_CYC + 1);
  localparam int EW        = $clog2(EN_TO_MAX_MS * MS_CYCLES + 1);

  logic          req_tgl, hold_wr;
  logic [7:0]    hold_addr, hold_wdata;
  logic [2:0]    short_sel_r, short_sel_nxt;
  logic [1:0]    ratio_r, ratio_nxt;
  logic          ovr_r, ovr_nxt, pen_r, pen_nxt, judge_r, judge_nxt;
  mode_t         mode_r, mode_nxt;
  logic [1:0]    limit_r, limit_nxt, atype_r, atype_nxt;
  logic [3:0]    fc_r, fc_nxt;
  logic [4:0]    seed_r, seed_nxt, cfg_r, cfg_nxt, quest_r, quest_nxt;
  logic [7:0]    answer_r, answer_nxt, rdata_r, rdata_nxt;
  logic          wrong_r, wrong_nxt, long_r, long_nxt;
  logic          short_r, short_nxt, err_r, err_nxt, bad_r, bad_nxt;
  logic [CW-1:0] cyc_r, cyc_nxt;
  logic [TW-1:0] tcnt_r, tcnt_nxt, mark_r, mark_nxt;
  logic          past_r, past_nxt, ack_r, ack_nxt;
  logic [PW-1:0] pcnt_r, pcnt_nxt;
  logic          prst_n_r, prst_n_nxt;
  logic [EW-1:0] ecnt_r, ecnt_nxt;
  logic          eerr_r, eerr_nxt;
  logic          req_s1_r, req_s2_r, req_s3_r;
  logic          wrst_s1_r, wrst_s2_r, esw_s1_r, esw_s2_r;
  logic [3:0]    esel_s1_r, esel_s2_r;

  logic          acc, wr, svc, early, wrong, tick, long_evt, enabled;
  logic          fc_clr, flg_clr, open_flag;
  logic [3:0]    inc, fc_base, esel;
  logic [4:0]    fc_sum;
  logic [TW-1:0] fast_lim, slow_lim, tcnt_inc;
  logic [7:0]    status;
  logic [EW-1:0] elim;

  wdog_link_port u_link (
    .lnk_clk_i    (lnk_clk_i),
    .lnk_rst_i    (lnk_rst_i),
    .lnk_req_i    (lnk_req_i),
    .lnk_wr_i     (lnk_wr_i),
    .lnk_addr_i   (lnk_addr_i),
    .lnk_wdata_i  (lnk_wdata_i),
    .ack_tgl_i    (ack_r),
    .ref_rdata_i  (rdata_r),
    .lnk_busy_o   (lnk_busy_o),
    .lnk_done_o   (lnk_done_o),
    .lnk_rdata_o  (lnk_rdata_o),
    .req_tgl_o    (req_tgl),
    .hold_wr_o    (hold_wr),
    .hold_addr_o  (hold_addr),
    .hold_wdata_o (hold_wdata)
  );

  always_comb
  begin
    fast_lim  = short_ms(short_sel_r);
    slow_lim  = long_ms(fast_lim, ratio_r);
    enabled   = (mode_r != MODE_OFF);
    acc       = req_s2_r ^ req_s3_r;
    wr        = acc && hold_wr;
    tick      = (cyc_r == CW'(MS_CYCLES - 1));
    tcnt_inc  = (tcnt_r == {TW{1'b1}}) ? tcnt_r : tcnt_r + TW'(1);
    svc       = wr && ((hold_addr == ADDR_RESTART &&
                        hold_wdata[RESTART_BIT] && mode_r == MODE_ACCESS) ||
                       (hold_addr == ADDR_ANSWER && mode_r[1]));
    // early service only in window type
    early     = svc && !judge_r && (tcnt_r < fast_lim);
    wrong     = svc && hold_addr == ADDR_ANSWER &&
                hold_wdata != expected_answer(quest_r, seed_r, atype_r);
    long_evt  = enabled && !svc && tick && (tcnt_inc == mark_r);
    if (long_evt && past_r && !ovr_r)
      inc = LONG_INC;
    else if (early || wrong || long_evt)
      inc = BAD_INC;
    else
      inc = 4'h0;
    fc_clr    = wr && hold_addr == ADDR_CLEAR && hold_wdata[FCCLR_BIT];
    flg_clr   = wr && hold_addr == ADDR_CLEAR && hold_wdata[FLGCLR_BIT];
    open_flag = enabled && tcnt_r >= fast_lim && tcnt_r <= slow_lim;
    status    = 8'h00;
    status[ST_WRONG] = wrong_r;
    status[ST_LONG]  = long_r;
    status[ST_SHORT] = short_r;
    status[ST_OPEN]  = open_flag;
    status[ST_ERR]   = err_r;
    status[ST_BAD]   = bad_r;
    esel      = (esel_s2_r > EN_TO_MAX_SEL) ? EN_TO_MAX_SEL : esel_s2_r;
    elim      = EW'((EN_TO_BASE_MS + EN_TO_STEP_MS * int'(esel))
                    * MS_CYCLES);

    short_sel_nxt = short_sel_r;
    ratio_nxt     = ratio_r;
    ovr_nxt       = ovr_r;
    pen_nxt       = pen_r;
    judge_nxt     = judge_r;
    mode_nxt      = mode_r;
    limit_nxt     = limit_r;
    seed_nxt      = seed_r;
    cfg_nxt       = cfg_r;
    quest_nxt     = quest_r;
    answer_nxt    = answer_r;
    atype_nxt     = atype_r;
    rdata_nxt     = rdata_r;
    ack_nxt       = ack_r ^ acc;

    if (wr)
    begin
      unique case (hold_addr)
        ADDR_TIMING:
        begin
          short_sel_nxt = hold_wdata[SHORT_LSB +: 3];
          ratio_nxt     = hold_wdata[RATIO_LSB +: 2];
        end
        ADDR_MODE:
        begin
          ovr_nxt   = hold_wdata[OVR_BIT];
          pen_nxt   = hold_wdata[PULSE_BIT];
          judge_nxt = hold_wdata[JUDGE_BIT];
          mode_nxt  = mode_t'(hold_wdata[MODE_LSB +: 2]);
        end
        ADDR_LIMIT:  limit_nxt  = hold_wdata[LIMIT_LSB +: 2];
        ADDR_SEED:
        begin
          seed_nxt  = hold_wdata[4:0];
          quest_nxt = hold_wdata[4:0];
        end
        ADDR_CFG:    cfg_nxt    = hold_wdata[4:0];
        ADDR_ANSWER: answer_nxt = hold_wdata;
        ADDR_ATYPE:  atype_nxt  = hold_wdata[1:0];
        default:     ;
      endcase
    end
    else if (acc)
    begin
      unique case (hold_addr)
        ADDR_TIMING: rdata_nxt = {1'b0, short_sel_r, 2'b00, ratio_r};
        ADDR_MODE:   rdata_nxt = {3'b000, ovr_r, pen_r, judge_r, mode_r};
        ADDR_LIMIT:  rdata_nxt = {fc_r, 2'b00, limit_r};
        ADDR_SEED:   rdata_nxt = {3'b000, seed_r};
        ADDR_CFG:    rdata_nxt = {3'b000, cfg_r};
        ADDR_QUEST:  rdata_nxt = {3'b000, quest_r};
        ADDR_ANSWER: rdata_nxt = answer_r;
        ADDR_ATYPE:  rdata_nxt = {6'h00, atype_r};
        ADDR_STATUS: rdata_nxt = status;
        default:     rdata_nxt = 8'h00;
      endcase
    end
    if (svc && hold_addr == ADDR_ANSWER)
      quest_nxt = next_question(quest_r, seed_r, cfg_r);
    // mode cleared while watched reset low
    if (!wrst_s2_r)
      mode_nxt = MODE_OFF;

    if (!enabled || svc)
    begin
      cyc_nxt  = '0;
      tcnt_nxt = '0;
      mark_nxt = slow_lim;
      past_nxt = 1'b0;
    end
    else
    begin
      cyc_nxt  = tick ? '0 : cyc_r + CW'(1);
      tcnt_nxt = tick ? tcnt_inc : tcnt_r;
      mark_nxt = mark_r;
      past_nxt = past_r | long_evt;
      if (long_evt)
      begin
        if (ovr_r)
        begin
          tcnt_nxt = '0;
          mark_nxt = slow_lim;
        end
        else
          mark_nxt = mark_r + slow_lim;
      end
    end

    fc_base = fc_clr ? 4'h0 : fc_r;
    fc_sum  = {1'b0, fc_base} + {1'b0, inc};
    fc_nxt  = (fc_sum > {1'b0, FC_MAX}) ? FC_MAX : fc_sum[3:0];
    wrong_nxt = wrong_r | wrong;
    long_nxt  = long_evt | (long_r & !flg_clr);
    short_nxt = early | (short_r & !flg_clr);
    bad_nxt   = (inc != 4'h0) | (bad_r & !flg_clr);
    err_nxt   = (enabled && fc_r >= fail_limit(limit_r)) |
                (err_r & !fc_clr);
    if (err_nxt && !err_r && pen_r)
      pcnt_nxt = PW'(PULSE_CYC);
    else if (pcnt_r != '0)
      pcnt_nxt = pcnt_r - PW'(1);
    else
      pcnt_nxt = '0;
    prst_n_nxt = (pcnt_nxt == '0);

    ecnt_nxt = ecnt_r;
    eerr_nxt = eerr_r;
    if (!wrst_s2_r || !esw_s2_r || enabled)
      ecnt_nxt = '0;
    else if (!eerr_r)
    begin
      ecnt_nxt = ecnt_r + EW'(1);
      if (ecnt_nxt == elim)
        eerr_nxt = 1'b1;
    end
    if (!wrst_s2_r)
      eerr_nxt = 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      short_sel_r <= SHORT_RST;
      ratio_r     <= RATIO_RST;
      ovr_r       <= 1'b0;
      pen_r       <= 1'b0;
      judge_r     <= 1'b0;
      mode_r      <= MODE_OFF;
      limit_r     <= LIMIT_RST;
      fc_r        <= 4'h0;
      seed_r      <= 5'h00;
      cfg_r       <= 5'h00;
      quest_r     <= 5'h00;
      answer_r    <= 8'h00;
      atype_r     <= 2'h0;
      rdata_r     <= 8'h00;
      ack_r       <= 1'b0;
      wrong_r     <= 1'b0;
      long_r      <= 1'b0;
      short_r     <= 1'b0;
      err_r       <= 1'b0;
      bad_r       <= 1'b0;
      cyc_r       <= '0;
      tcnt_r      <= '0;
      mark_r      <= '0;
      past_r      <= 1'b0;
      pcnt_r      <= '0;
      prst_n_r    <= 1'b1;
      ecnt_r      <= '0;
      eerr_r      <= 1'b0;
      req_s1_r    <= 1'b0;
      req_s2_r    <= 1'b0;
      req_s3_r    <= 1'b0;
      wrst_s1_r   <= 1'b0;
      wrst_s2_r   <= 1'b0;
      esw_s1_r    <= 1'b0;
      esw_s2_r    <= 1'b0;
      esel_s1_r   <= 4'h0;
      esel_s2_r   <= 4'h0;
    end
    else
    begin
      short_sel_r <= short_sel_nxt;
      ratio_r     <= ratio_nxt;
      ovr_r       <= ovr_nxt;
      pen_r       <= pen_nxt;
      judge_r     <= judge_nxt;
      mode_r      <= mode_nxt;
      limit_r     <= limit_nxt;
      fc_r        <= fc_nxt;
      seed_r      <= seed_nxt;
      cfg_r       <= cfg_nxt;
      quest_r     <= quest_nxt;
      answer_r    <= answer_nxt;
      atype_r     <= atype_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
      wrong_r     <= wrong_nxt;
      long_r      <= long_nxt;
      short_r     <= short_nxt;
      err_r       <= err_nxt;
      bad_r       <= bad_nxt;
      cyc_r       <= cyc_nxt;
      tcnt_r      <= tcnt_nxt;
      mark_r      <= mark_nxt;
      past_r      <= past_nxt;
      pcnt_r      <= pcnt_nxt;
      prst_n_r    <= prst_n_nxt;
      ecnt_r      <= ecnt_nxt;
      eerr_r      <= eerr_nxt;
      req_s1_r    <= req_tgl;
      req_s2_r    <= req_s1_r;
      req_s3_r    <= req_s2_r;
      wrst_s1_r   <= watched_reset_n_i;
      wrst_s2_r   <= wrst_s1_r;
      esw_s1_r    <= enable_timeout_switch_i;
      esw_s2_r    <= esw_s1_r;
      esel_s1_r   <= enable_timeout_sel_i;
      esel_s2_r   <= esel_s1_r;
    end
  end

  assign interrupt_out_n_o      = ~err_r;
  assign power_reset_out_n_o    = prst_n_r;
  assign enable_timeout_error_o = eerr_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_mode_clear;
    !wrst_s2_r |=> mode_r == MODE_OFF;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("mode not cleared under watched reset");

  property p_short_flag;
    early |=> short_r && bad_r;
  endproperty
  a_short_flag: assert property (p_short_flag)
    else $error("early service not flagged");

  property p_timeout_type;
    svc && judge_r && !short_r |=> !short_r;
  endproperty
  a_timeout_type: assert property (p_timeout_type)
    else $error("short limit judged in timeout type");

  property p_restart;
    svc |=> tcnt_r == '0 && cyc_r == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("service did not restart counter");

  property p_fail_err;
    enabled && fc_r >= fail_limit(limit_r) |=> err_r;
  endproperty
  a_fail_err: assert property (p_fail_err)
    else $error("fail limit reached without error");

  property p_int_low;
    enabled && fc_r >= fail_limit(limit_r) |=> !interrupt_out_n_o;
  endproperty
  a_int_low: assert property (p_int_low)
    else $error("interrupt not low on error");

  property p_pulse;
    $rose(err_r) && $past(pen_r) |-> !power_reset_out_n_o [*8];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse missing");

  property p_fc_clear;
    fc_clr && inc == 4'h0 |=> fc_r == 4'h0;
  endproperty
  a_fc_clear: assert property (p_fc_clear)
    else $error("fail count not cleared");

  property p_flag_clear;
    flg_clr && !long_evt && !early && inc == 4'h0
      |=> !long_r && !short_r && !bad_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flags not cleared");

  property p_bad;
    wrong || long_evt |=> bad_r;
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad event flag not set");

  property p_long_reset;
    long_evt && ovr_r |=> tcnt_r == '0;
  endproperty
  a_long_reset: assert property (p_long_reset)
    else $error("counter not restarted after long timeout");

  property p_long_twice;
    long_evt && past_r && !ovr_r && !fc_clr && fc_r <= 4'hD
      |=> fc_r == $past(fc_r) + 4'h2;
  endproperty
  a_long_twice: assert property (p_long_twice)
    else $error("repeated long timeout did not add two");

  c_good_answer: cover property (svc && mode_r[1] && !wrong);
  c_error: cover property ($rose(err_r));
  c_long: cover property (long_evt && past_r);
  c_pulse: cover property ($fell(power_reset_out_n_o));

endmodule // question_answer_window_watchdog

// File: tb/host_bfm.sv
module host_bfm (
  input  wire logic       lnk_clk_i,
  input  wire logic       done_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] rdata_i,
  output logic            req_o,
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            hung_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    hung_o = 1'b0;
  end
  // answers and all bytes go one at a time
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge lnk_clk_i);
    req_o <= 1'b1;
    wr_o <= w;
    addr_o <= a;
    wdata_o <= d;
    do
    begin
      @(posedge lnk_clk_i);
      n++;
      // taken at first edge with busy low; drop so it is not taken twice
      if (req_o && busy_i === 1'b0)
        req_o <= 1'b0;
    end
    while (done_i !== 1'b1 && n < 40);
    q = rdata_i;
    if (n >= 40)
      hung_o <= 1'b1;
    // released lines show garbage, not the old value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // host_bfm

// File: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wdog_pkg::*;
  logic       clk = 1'b0;
  logic       lclk = 1'b0;
  logic       rst, lrst, wrst_n, ets, hung, req, wr_en, done, busy;
  logic       irq_n, prst_n, eto;
  logic [3:0] etsel;
  logic [7:0] addr, wdata, rdata, q;
  logic [4:0] qq;
  int         errors, checks_done, cyc, n;
  logic [7:0] rv [11] = '{8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #25 clk = ~clk;
  initial
  begin
    #7.3;
    forever #32 lclk = ~lclk;
  end

  question_answer_window_watchdog #(.MS_CYCLES(20))
    i_question_answer_window_watchdog (
    .ref_clk_i(clk), .sys_rst_i(rst), .lnk_clk_i(lclk),
    .lnk_rst_i(lrst), .lnk_req_i(req), .lnk_wr_i(wr_en),
    .lnk_addr_i(addr), .lnk_wdata_i(wdata), .lnk_busy_o(busy),
    .lnk_done_o(done), .lnk_rdata_o(rdata), .watched_reset_n_i(wrst_n),
    .enable_timeout_switch_i(ets), .enable_timeout_sel_i(etsel),
    .interrupt_out_n_o(irq_n), .power_reset_out_n_o(prst_n),
    .enable_timeout_error_o(eto));

  host_bfm i_host_bfm (
    .lnk_clk_i(lclk), .done_i(done), .busy_i(busy), .rdata_i(rdata),
    .req_o(req),
    .wr_o(wr_en), .addr_o(addr), .wdata_o(wdata), .hung_o(hung));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_bfm.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF);
    i_host_bfm.xfer(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // disable through the watched reset, then clear fail count, error, long, short and bad flags
  task automatic off();
    wrst_n <= 1'b0;
    waitc(4);
    wr(ADDR_CLEAR, 8'h03);
    wrst_n <= 1'b1;
    waitc(4);
  endtask
  task automatic report_and_stop();
    errors = errors + int'(hung === 1'b1);
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] ans(logic [4:0] x, logic [4:0] s,
                                     logic [1:0] t);
    logic [7:0] b;
    b = {x[2:0] ^ s[2:0], x};
    return (b << t) | (b >> (4'd8 - t));
  endfunction

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    rst = 1'b1;
    lrst = 1'b1;
    wrst_n = 1'b0;
    ets = 1'b0;
    etsel = 4'h0;
    cyc = 0;
    errors = 0;
    checks_done = 0;
    waitc(16);
    rst <= 1'b0;
    lrst <= 1'b0;
    wrst_n <= 1'b1;
    waitc(4);
    for (int i = 0; i < 11; i++)
      rc(8'(64 + i), rv[i]);
    rc(8'h4B, 8'h00);
    $display("end regs");
    wr(ADDR_SEED, 8'h15);
    rc(ADDR_SEED, 8'h15);
    rc(ADDR_QUEST, 8'h15);
    wr(ADDR_QUEST, 8'h0A);
    rc(ADDR_QUEST, 8'h15);
    wr(ADDR_CFG, 8'hE6);
    rc(ADDR_CFG, 8'h06);
    wrst_n <= 1'b0;
    waitc(4);
    wr(ADDR_MODE, 8'h01);
    rc(ADDR_MODE, 8'h00);
    wrst_n <= 1'b1;
    waitc(4);
    wr(ADDR_MODE, 8'h01);
    rc(ADDR_MODE, 8'h01);
    off();
    rc(ADDR_MODE, 8'h00);
    $display("end mode");
    wr(ADDR_TIMING, 8'h11);
    wr(ADDR_MODE, 8'h01);
    waitc(50);
    rc(ADDR_STATUS, 8'h04);
    wr(ADDR_RESTART, 8'h01);
    rc(ADDR_RESTART, 8'h00);
    rc(ADDR_LIMIT, 8'h02);
    wr(ADDR_RESTART, 8'h01);
    rc(ADDR_LIMIT, 8'h12);
    rc(ADDR_STATUS, 8'h09, 8'hFB);
    wr(ADDR_CLEAR, 8'h01);
    rc(ADDR_STATUS, 8'h00, 8'hFB);
    rc(ADDR_CLEAR, 8'h00);
    wr(ADDR_CLEAR, 8'h02);
    rc(ADDR_LIMIT, 8'h02);
    off();
    $display("end window");
    wr(ADDR_TIMING, 8'h10);
    wr(ADDR_LIMIT, 8'h03);
    wr(ADDR_MODE, 8'h15);
    wr(ADDR_RESTART, 8'h01);
    waitc(200);
    rc(ADDR_LIMIT, 8'h23);
    chk(8'(irq_n), 8'h01);
    off();
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_RESTART, 8'h01);
    waitc(200);
    rc(ADDR_LIMIT, 8'h33);
    rc(ADDR_STATUS, 8'h11);
    off();
    wr(ADDR_LIMIT, 8'h00);
    wr(ADDR_MODE, 8'h1D);
    n = 0;
    while (prst_n !== 1'b0 && n < 300)
    begin
      waitc(1);
      n++;
    end
    n = 0;
    fork
      rc(ADDR_LIMIT, 8'h10);
      while (prst_n === 1'b0 && n < 300)
      begin
        waitc(1);
        n++;
      end
    join
    chk(8'(n), 8'd100);
    chk(8'(irq_n), 8'h00);
    rc(ADDR_STATUS, 8'h13, 8'hFB);
    off();
    chk(8'(irq_n), 8'h01);
    $display("end timeout");
    wr(ADDR_TIMING, 8'h11);
    wr(ADDR_SEED, 8'h15);
    qq = 5'h15;
    wr(ADDR_MODE, 8'h06);
    for (int t = 0; t < 4; t++)
    begin
      wr(ADDR_ATYPE, 8'(t));
      wr(ADDR_ANSWER, ans(qq, 5'h15, 2'(t)));
      qq = {qq[3:0], ~(qq[4] ^ qq[2])} ^ (5'h15 ^ 5'h06);
      rc(ADDR_QUEST, {3'h0, qq});
    end
    rc(ADDR_LIMIT, 8'h00);
    wr(ADDR_MODE, 8'h07);
    wr(ADDR_ANSWER, ~ans(qq, 5'h15, 2'd3));
    rc(ADDR_LIMIT, 8'h10);
    rc(ADDR_STATUS, 8'h23, 8'hFB);
    off();
    $display("end answers");
    wrst_n <= 1'b0;
    ets <= 1'b1;
    waitc(4);
    wrst_n <= 1'b1;
    waitc(1900);
    chk(8'(eto), 8'h00);
    waitc(200);
    chk(8'(eto), 8'h01);
    wrst_n <= 1'b0;
    waitc(4);
    chk(8'(eto), 8'h00);
    wrst_n <= 1'b1;
    waitc(4);
    wr(ADDR_MODE, 8'h06);
    waitc(2100);
    chk(8'(eto), 8'h00);
    off();
    $display("end enable");
    report_and_stop();
  end
endmodule // tb_top
